// File: afs_bank.sv
/*
  fault and warning status bank of a stereo switching amplifier, with pin masks,
  latch enables, fault clear, output stage high impedance and fault pin report.
  assumes sense levels come from asynchronous analog circuits and load results
  and the control port request come from logic on mclk_i.
*/
`timescale 1ns/1ps
`include "afs_cfg.svh"

// How it works
// - clock fault sets status A bit 2, floats outputs, reports on fault pin.
// - output float follows live clock fault, so recovery needs no software.
// - supply over-voltage sets status A bit 1, floats outputs, reports on pin.
// - supply under-voltage sets status A bit 0, floats outputs, reports on pin.
// - supply faults float outputs only while present, resuming automatically.
// - thermal shutdown sets status B bit 0, floats outputs, reports, recovers alone.
// - set protection fault bits stay one, when latch enabled, until host writes one to clear bit 7; load error bits change only on the next load result.
// - failed one-time memory integrity check sets status A bit 7.
// - failed latest coefficient write sets status A bit 6.
// - status A bit 5 shows outcome of the last boot load.
// - cycle over-current faults: status B bit 2 right, bit 1 left.
// - cycle over-current warnings: warning bit 5 left, bit 4 right.
// - warning bit 3 at 146C, bit 2 at 134C.
// - warning bit 1 at 122C, bit 0 at 112C.
// - warning register resets to zero and is read-only.
// - clock fault mask hides clock faults from the pin, still recorded.
// - thermal shutdown latch enable resets to one; zero makes status live.
module afs_bank
  import afs_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // protection sense levels
  input afs_sense_t sense_i,
  // configuration load results
  input afs_load_t load_i,
  // control port
  input afs_req_t req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // output stage and fault pin
  output logic output_hiz_o,
  output logic fault_n_o
);

  typedef struct packed {
    logic [7:0] status_a;
    logic [7:0] status_b;
    logic [7:0] warning;
    logic [7:0] mask_a;
    logic [7:0] mask_b;
    logic [7:0] rdata;
    logic rvalid;
    logic hiz;
    logic fault_n;
  } afs_state_t;

  afs_state_t st;
  afs_state_t next_st;
  afs_sense_t live;
  logic [$bits(afs_sense_t)-1:0] live_bits;
  logic clr;
  logic live_float;
  logic report;

  // sticky when latching, otherwise a copy of the live level; set wins over clear
  function automatic logic track(input logic cur, input logic lvl, input logic latch_on, input logic clear);
    logic res;
    res = lvl;
    if (latch_on) begin
      res = (cur & ~clear) | lvl;
    end
    return res;
  endfunction : track

  afs_sync #(
    .WIDTH($bits(afs_sense_t))
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(sense_i),
    .sync_o(live_bits)
  );

  assign live = afs_sense_t'(live_bits);

  // clear pulse from the fault clear register
  assign clr = req_i.wr && (req_i.addr == `AFS_OFS_FAULT_CLEAR) && req_i.wdata[`AFS_CLR_BIT];

  // outputs float only while a fault is present
  assign live_float = live.clk_fault
    | live.supply_overvolt_flag
    | live.supply_undervolt_flag
    | live.thermal_shutdown_flag;

  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;

    // status A: supply and clock faults
    next_st.status_a[`AFS_GA_CLK_FAULT] = track(st.status_a[`AFS_GA_CLK_FAULT], live.clk_fault,
      st.mask_b[`AFS_MB_CLK_LATCH], clr);
    next_st.status_a[`AFS_GA_SUPPLY_OVERVOLT] = track(st.status_a[`AFS_GA_SUPPLY_OVERVOLT],
      live.supply_overvolt_flag, 1'b1, clr);
    next_st.status_a[`AFS_GA_SUPPLY_UNDERVOLT] = track(st.status_a[`AFS_GA_SUPPLY_UNDERVOLT],
      live.supply_undervolt_flag, 1'b1, clr);

    // status A: configuration load errors
    if (load_i.otp_check_done) begin
      next_st.status_a[`AFS_GA_OTP_CHECK_FAILED] = ~load_i.otp_check_ok;
    end
    if (load_i.coef_write_done) begin
      next_st.status_a[`AFS_GA_COEF_WRITE_FAILED] = ~load_i.coef_write_ok;
    end
    if (load_i.boot_load_done) begin
      next_st.status_a[`AFS_GA_BOOT_LOAD_FAILED] = ~load_i.boot_load_ok;
    end

    // status B: thermal shutdown and cycle over-current faults
    next_st.status_b[`AFS_GB_THERMAL_SHUTDOWN] = track(st.status_b[`AFS_GB_THERMAL_SHUTDOWN],
      live.thermal_shutdown_flag, st.mask_b[`AFS_MB_THERMAL_LATCH], clr);
    next_st.status_b[`AFS_GB_RIGHT_CYC_OC] = track(st.status_b[`AFS_GB_RIGHT_CYC_OC],
      live.right_cyc_overcurrent_fault, st.mask_b[`AFS_MB_CYC_FAULT_LATCH], clr);
    next_st.status_b[`AFS_GB_LEFT_CYC_OC] = track(st.status_b[`AFS_GB_LEFT_CYC_OC],
      live.left_cyc_overcurrent_fault, st.mask_b[`AFS_MB_CYC_FAULT_LATCH], clr);

    // warnings: cycle over-current per channel
    next_st.warning[`AFS_WS_LEFT_CYC_OC] = track(st.warning[`AFS_WS_LEFT_CYC_OC],
      live.left_cyc_overcurrent_warn, st.mask_b[`AFS_MB_CYC_WARN_LATCH], clr);
    next_st.warning[`AFS_WS_RIGHT_CYC_OC] = track(st.warning[`AFS_WS_RIGHT_CYC_OC],
      live.right_cyc_overcurrent_warn, st.mask_b[`AFS_MB_CYC_WARN_LATCH], clr);

    // warnings: graded die temperature
    next_st.warning[`AFS_WS_THERMAL_TOP] = track(st.warning[`AFS_WS_THERMAL_TOP],
      live.thermal_warn_top, 1'b1, clr);
    next_st.warning[`AFS_WS_THERMAL_HIGH] = track(st.warning[`AFS_WS_THERMAL_HIGH],
      live.thermal_warn_high, 1'b1, clr);
    next_st.warning[`AFS_WS_THERMAL_MID] = track(st.warning[`AFS_WS_THERMAL_MID],
      live.thermal_warn_mid, 1'b1, clr);
    next_st.warning[`AFS_WS_THERMAL_LOW] = track(st.warning[`AFS_WS_THERMAL_LOW],
      live.thermal_warn_low, 1'b1, clr);

    // reserved bits held at zero
    next_st.status_a[4:3] = 2'h0;
    next_st.status_b[7:3] = 5'h00;
    next_st.warning[7:6] = 2'h0;

    // writable mask and latch control; status registers ignore writes
    if (req_i.wr) begin
      unique case (req_i.addr)
        `AFS_OFS_FAULT_PIN_MASK_A: begin
          next_st.mask_a = req_i.wdata & `AFS_MA_WRITE_MASK;
        end
        `AFS_OFS_FAULT_PIN_MASK_B: begin
          next_st.mask_b = req_i.wdata;
        end
        default: begin
          next_st.mask_a = st.mask_a;
        end
      endcase
    end

    // read data one cycle after the request
    if (req_i.rd) begin
      next_st.rvalid = 1'b1;
      unique case (req_i.addr)
        `AFS_OFS_GLOBAL_FAULT_STATUS_A: begin
          next_st.rdata = st.status_a;
        end
        `AFS_OFS_GLOBAL_FAULT_STATUS_B: begin
          next_st.rdata = st.status_b;
        end
        `AFS_OFS_WARNING_STATUS: begin
          next_st.rdata = st.warning;
        end
        `AFS_OFS_FAULT_PIN_MASK_A: begin
          next_st.rdata = st.mask_a;
        end
        `AFS_OFS_FAULT_PIN_MASK_B: begin
          next_st.rdata = st.mask_b;
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end

    next_st.hiz = live_float;
    next_st.fault_n = ~report;
  end

  // fault pin report from recorded faults, each behind its mask
  always_comb begin
    report = 1'b0;
    if (st.status_a[`AFS_GA_CLK_FAULT] && !st.mask_a[`AFS_MA_CLK_FAULT]) begin
      report = 1'b1;
    end
    if ((st.status_a[`AFS_GA_SUPPLY_OVERVOLT] || st.status_a[`AFS_GA_SUPPLY_UNDERVOLT])
        && !st.mask_a[`AFS_MA_SUPPLY]) begin
      report = 1'b1;
    end
    if (st.status_b[`AFS_GB_THERMAL_SHUTDOWN] && !st.mask_a[`AFS_MA_THERMAL_SHUTDOWN]) begin
      report = 1'b1;
    end
    if ((st.status_b[`AFS_GB_RIGHT_CYC_OC] || st.status_b[`AFS_GB_LEFT_CYC_OC])
        && !st.mask_b[`AFS_MB_CYC_OC_FAULT]) begin
      report = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st.status_a <= `AFS_RST_STATUS;
      st.status_b <= `AFS_RST_STATUS;
      st.warning <= `AFS_RST_STATUS;
      st.mask_a <= `AFS_RST_MASK_A;
      st.mask_b <= `AFS_RST_MASK_B;
      st.rdata <= 8'h00;
      st.rvalid <= 1'b0;
      st.hiz <= 1'b0;
      st.fault_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign rvalid_o = st.rvalid;
  assign output_hiz_o = st.hiz;
  assign fault_n_o = st.fault_n;

endmodule : afs_bank

// File: afs_cfg.svh
/*
  offsets, field positions, reset values and masks of the amplifier fault status bank.
  assumes it is included by its bare name wherever these constants are needed.
*/
`ifndef AFS_CFG_SVH
`define AFS_CFG_SVH

// register offsets on the control port
`define AFS_OFS_GLOBAL_FAULT_STATUS_A 8'h71
`define AFS_OFS_GLOBAL_FAULT_STATUS_B 8'h72
`define AFS_OFS_WARNING_STATUS 8'h73
`define AFS_OFS_FAULT_PIN_MASK_A 8'h74
`define AFS_OFS_FAULT_PIN_MASK_B 8'h75
`define AFS_OFS_FAULT_CLEAR 8'h78

// global_fault_status_a fields
`define AFS_GA_SUPPLY_UNDERVOLT 0
`define AFS_GA_SUPPLY_OVERVOLT 1
`define AFS_GA_CLK_FAULT 2
`define AFS_GA_BOOT_LOAD_FAILED 5
`define AFS_GA_COEF_WRITE_FAILED 6
`define AFS_GA_OTP_CHECK_FAILED 7

// global_fault_status_b fields
`define AFS_GB_THERMAL_SHUTDOWN 0
`define AFS_GB_LEFT_CYC_OC 1
`define AFS_GB_RIGHT_CYC_OC 2

// warning_status fields
`define AFS_WS_THERMAL_LOW 0
`define AFS_WS_THERMAL_MID 1
`define AFS_WS_THERMAL_HIGH 2
`define AFS_WS_THERMAL_TOP 3
`define AFS_WS_RIGHT_CYC_OC 4
`define AFS_WS_LEFT_CYC_OC 5

// fault_pin_mask_a fields
`define AFS_MA_CYC_OC 0
`define AFS_MA_SUPPLY 2
`define AFS_MA_CLK_FAULT 4
`define AFS_MA_THERMAL_SHUTDOWN 7
`define AFS_MA_WRITE_MASK 8'hf7

// fault_pin_mask_b fields
`define AFS_MB_CYC_OC_FAULT 0
`define AFS_MB_THERMAL_LATCH 4
`define AFS_MB_CLK_LATCH 5
`define AFS_MB_CYC_WARN_LATCH 6
`define AFS_MB_CYC_FAULT_LATCH 7

// fault clear register field
`define AFS_CLR_BIT 7

// reset values
`define AFS_RST_STATUS 8'h00
`define AFS_RST_MASK_A 8'h00
`define AFS_RST_MASK_B 8'hf8

`endif

// File: afs_host.sv
/*
  host controller model on the control port.
  assumes requests are driven on the falling edge of mclk_i.
*/
`timescale 1ns/1ps
module afs_host
  import afs_pkg::*;
(
  // clock
  input wire logic mclk_i,
  // control port
  output afs_req_t req_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    req_o <= '{1'b0, 1'b1, a, d};
    @(negedge mclk_i);
    req_o <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic clr();
    wr(8'h78, 8'h80);
  endtask : clr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge mclk_i);
    req_o <= '{1'b1, 1'b0, a, ~a};
    @(negedge mclk_i);
    req_o <= '{1'b0, 1'b0, ~a, a};
    // answer stands only in the cycle after the taking edge, so look at this falling edge first
    for (int i = 0; i < 4 && !ok; i++) begin
      ok = rvalid_i;
      d = rdata_i;
      if (!ok) begin
        @(negedge mclk_i);
      end
    end
  endtask : rd
endmodule : afs_host

// File: afs_monitor.sv
/*
  port checks of afs_bank.
  assumes afs_pkg is compiled first; bound at the foot.
*/
`timescale 1ns/1ps
module afs_monitor
  import afs_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // watched ports
  input afs_sense_t sense_i,
  input afs_load_t load_i,
  input afs_req_t req_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic output_hiz_o,
  input wire logic fault_n_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] mask_a;
  logic hot;
  assign hot = sense_i.clk_fault | sense_i.supply_overvolt_flag | sense_i.supply_undervolt_flag
    | sense_i.thermal_shutdown_flag;
  // mirror of the pin mask written by the host
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mask_a <= 8'h00;
    end else if (req_i.wr && req_i.addr == 8'h74) begin
      mask_a <= req_i.wdata;
    end
  end
  sequence rd_at(logic [7:0] a);
    req_i.rd && req_i.addr == a;
  endsequence
  rd_answer_a: assert property (req_i.rd |=> rvalid_o)
    else $error("read not answered");
  hiz_on_fault_a: assert property (hot [*8] |-> output_hiz_o)
    else $error("outputs not floated");
  hiz_recover_a: assert property (!hot [*8] |-> !output_hiz_o)
    else $error("outputs not recovered");
  ov_pin_a: assert property ((!mask_a[2] throughout sense_i.supply_overvolt_flag [*8]) |-> !fault_n_o)
    else $error("overvolt not on pin");
  uv_status_a: assert property (sense_i.supply_undervolt_flag [*8] ##0 rd_at(8'h71) |=> rdata_o[0])
    else $error("undervolt not recorded");
  clk_status_a: assert property (sense_i.clk_fault [*8] ##0 rd_at(8'h71) |=> rdata_o[2])
    else $error("clock fault not recorded");
  rcyc_fault_a: assert property (sense_i.right_cyc_overcurrent_fault [*8] ##0 rd_at(8'h72) |=> rdata_o[2])
    else $error("right overcurrent not recorded");
  lwarn_status_a: assert property (sense_i.left_cyc_overcurrent_warn [*8] ##0 rd_at(8'h73) |=> rdata_o[5])
    else $error("left warning not recorded");
  otp_fail_a: assert property (load_i.otp_check_done && !load_i.otp_check_ok ##[1:2] rd_at(8'h71) |=> rdata_o[7])
    else $error("memory check failure not shown");
  boot_ok_a: assert property (load_i.boot_load_done && load_i.boot_load_ok ##[1:2] rd_at(8'h71) |=> !rdata_o[5])
    else $error("boot success not shown");
  rsvd_zero_a: assert property (rvalid_o && $past(req_i.addr) == 8'h72 |-> rdata_o[7:3] == 5'h00)
    else $error("reserved bits not zero");
endmodule : afs_monitor

bind afs_bank afs_monitor i_afs_monitor(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sense_i(sense_i),
  .load_i(load_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .output_hiz_o(output_hiz_o), .fault_n_o(fault_n_o));

// File: afs_pkg.sv
/*
  types of the amplifier fault status bank: sense bundle, load result bundle and control port request.
  assumes afs_cfg.svh sits in the same folder.
*/
package afs_pkg;

  // live conditions from the protection sensing circuits
  typedef struct packed {
    logic clk_fault;
    logic supply_overvolt_flag;
    logic supply_undervolt_flag;
    logic thermal_shutdown_flag;
    logic left_cyc_overcurrent_fault;
    logic right_cyc_overcurrent_fault;
    logic left_cyc_overcurrent_warn;
    logic right_cyc_overcurrent_warn;
    logic thermal_warn_top;
    logic thermal_warn_high;
    logic thermal_warn_mid;
    logic thermal_warn_low;
  } afs_sense_t;

  // configuration load results from same-clock logic
  typedef struct packed {
    logic otp_check_done;
    logic otp_check_ok;
    logic coef_write_done;
    logic coef_write_ok;
    logic boot_load_done;
    logic boot_load_ok;
  } afs_load_t;

  // one access from the control port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } afs_req_t;

endpackage : afs_pkg

// File: afs_sync.sv
/*
  three-stage synchroniser per bit with agreement filter.
  assumes inputs arrive from outside the mclk_i domain.
*/
`timescale 1ns/1ps

module afs_sync #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // raw and filtered levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] held;
  } afs_sync_state_t;

  afs_sync_state_t st;
  afs_sync_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = async_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.held[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.held;

endmodule : afs_sync

// File: tb_afs_bank.sv
/*
  self-checking bench of afs_bank with host model.
  assumes afs_pkg, afs_host and afs_monitor are compiled first.
*/
`timescale 1ns/1ps
module tb_afs_bank;
  import afs_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  afs_sense_t sense = '0;
  afs_load_t load = '0;
  afs_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic hiz;
  logic fault_n;
  int mismatches = 0;
  int cmp_count = 0;
  afs_sense_t s;
  logic [2:0] r;
  logic [7:0] a_tab[6] = '{8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h77};
  logic [7:0] r_tab[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hf8, 8'h00};
  initial forever #20 mclk_i = ~mclk_i;
  afs_bank i_afs_bank(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sense_i(sense), .load_i(load), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .output_hiz_o(hiz), .fault_n_o(fault_n));
  afs_host i_afs_host(.mclk_i(mclk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));
  function automatic logic [7:0] exp_reg(afs_sense_t v, int i);
    case (i)
      0: return {5'h00, v.clk_fault, v.supply_overvolt_flag, v.supply_undervolt_flag};
      1: return {5'h00, v.right_cyc_overcurrent_fault, v.left_cyc_overcurrent_fault, v.thermal_shutdown_flag};
      default: return {2'h0, v.left_cyc_overcurrent_warn, v.right_cyc_overcurrent_warn,
        v.thermal_warn_top, v.thermal_warn_high, v.thermal_warn_mid, v.thermal_warn_low};
    endcase
  endfunction : exp_reg
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    i_afs_host.rd(a, d, ok);
    if (!ok) begin
      mismatches++;
      end_sim();
    end else begin
      chk($sformatf("reg %h", a), d, e);
    end
  endtask : rdc
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : cyc
  initial begin
    void'($urandom(32'haba3));
    cyc(12);
    rst_n_i = 1'b1;
    for (int i = 0; i < 6; i++) rdc(a_tab[i], r_tab[i]);
    for (int i = 0; i < 3; i++) begin
      i_afs_host.wr(a_tab[i], 8'hff);
      rdc(a_tab[i], 8'h00);
    end
    i_afs_host.wr(8'h74, 8'hff);
    rdc(8'h74, 8'hf7);
    for (int n = 0; n < 12; n++) begin
      s = (n < 2) ? (n ? '1 : '0) : afs_sense_t'(12'($urandom));
      i_afs_host.wr(8'h74, 8'h00);
      i_afs_host.clr();
      sense = s;
      cyc(8);
      chk("hiz", {7'h00, hiz}, {7'h00, s.clk_fault | s.supply_overvolt_flag | s.supply_undervolt_flag
        | s.thermal_shutdown_flag});
      chk("fault pin", {7'h00, fault_n}, {7'h00, ~(|exp_reg(s, 0) | |exp_reg(s, 1))});
      for (int i = 0; i < 3; i++) rdc(a_tab[i], exp_reg(s, i));
      sense = '0;
      cyc(8);
      chk("hiz", {7'h00, hiz}, 8'h00);
      for (int i = 0; i < 3; i++) rdc(a_tab[i], exp_reg(s, i));
      i_afs_host.clr();
      for (int i = 0; i < 3; i++) rdc(a_tab[i], 8'h00);
    end
    for (int n = 0; n < 5; n++) begin
      r = n ? 3'($urandom) : 3'h7;
      load = {1'b1, r[2], 1'b1, r[1], 1'b1, r[0]};
      cyc(1);
      load = '0;
      rdc(8'h71, {~r, 5'h00});
    end
    i_afs_host.wr(8'h74, 8'h10);
    s = '0;
    s.clk_fault = 1'b1;
    sense = s;
    cyc(8);
    chk("fault pin", {7'h00, fault_n}, 8'h01);
    rdc(8'h71, {r_tab[0][7:3], 3'h4} | {~r, 5'h00});
    sense = '0;
    i_afs_host.wr(8'h75, 8'he8);
    s = '0;
    s.thermal_shutdown_flag = 1'b1;
    sense = s;
    cyc(8);
    sense = '0;
    cyc(8);
    rdc(8'h72, 8'h00);
    end_sim();
  end
endmodule : tb_afs_bank
